/* common/optical_module_regs.svh */
// offsets, field positions and timing counts of the module control and status block
//
// Contract
// - Laser fault output goes high on a laser fault, stays low otherwise.
// - Transmitter on while the off input is low; off when high or open.
// - Presence line is tied to ground so the host sees an installed module.
// - Definition lines one and two carry serial clock and serial data.
// - Signal-lost output high below receiver sensitivity, low when reception is normal.
// - Optical output drops within 10 us of the off input rising.
// - Optical output returns within 1 ms of the off input falling.
// - Initialisation, including fault clear, ends within 300 ms of power-on or release.
// - Laser fault output asserts within 100 us of a fault.
// - Signal-lost output follows loss and recovery within 100 us each way.
// - Soft disable bit 6 of byte 110 turns output off and on within 100 ms.
// - Soft fault bit 2 of byte 110 sets within 100 ms of a fault.
// - Soft signal-lost bit 1 of byte 110 follows loss within 100 ms.
// - Data-ready bit 0 of byte 110 sets within 1000 ms of power-on.
// - Serial bus transactions are accepted no later than 300 ms after power-on.
// - A write of one to eight bytes completes within 10 ms of its stop.
// - Module answers reads and writes at two device addresses.
// - Bit 7 of byte 110 shows the present level of the off input.
`ifndef OPTICAL_MODULE_REGS_SVH
`define OPTICAL_MODULE_REGS_SVH

`define CLK_HZ          10000000
`define DEV_ID_ADDR     8'ha0
`define DEV_DIAG_ADDR   8'ha2
`define STATUS_BYTE     8'h6e
`define ST_TXOFF_BIT    7
`define ST_SOFTDIS_BIT  6
`define ST_FAULT_BIT    2
`define ST_LOST_BIT     1
`define ST_READY_BIT    0
`define MEM_DEPTH       512

`define T_OFF_US        10
`define T_OFF_CYC       (`T_OFF_US * (`CLK_HZ / 1000000))
`define T_FAULT_US      100
`define T_FAULT_CYC     (`T_FAULT_US * (`CLK_HZ / 1000000))
`define T_RESET_US      10
`define T_RESET_CYC     ((`T_RESET_US * `CLK_HZ + 999999) / 1000000)
`define T_LOSS_US       100
`define T_LOSS_CYC      (`T_LOSS_US * (`CLK_HZ / 1000000))
`define T_DATA_MS       1000
`define T_DATA_CYC      (`T_DATA_MS * (`CLK_HZ / 1000))
`define T_SERIAL_MS     300
`define T_SERIAL_CYC    (`T_SERIAL_MS * (`CLK_HZ / 1000))
`define T_WRITE_MS      10
`define T_WRITE_CYC     (`T_WRITE_MS * (`CLK_HZ / 1000))

`endif

/* common/optical_module_pkg.sv */
// types shared by the module control block and its serial slave
package optical_module_pkg;

    typedef enum logic [3:0]
    {
        st_idle = 4'h0,
        st_addr = 4'h1,
        st_aack = 4'h2,
        st_reg  = 4'h3,
        st_rack = 4'h4,
        st_wr   = 4'h5,
        st_wack = 4'h6,
        st_rd   = 4'h7,
        st_mack = 4'h8
    } twowire_state_e;

    typedef struct packed
    {
        logic       wr_stb;
        logic       stop_wr;
        logic       dev;
        logic [7:0] addr;
        logic [7:0] data;
    } bus_req_s;

endpackage : optical_module_pkg

/* core/twowire_slave.sv */
// two-wire serial slave with a byte pointer, answering at two device addresses
`timescale 1ns/1ps
`include "optical_module_regs.svh"
module twowire_slave
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // synchronised bus levels
    input  wire logic                        scl_s,
    input  wire logic                        sda_s,
    // memory side
    input  wire logic                        accept,
    input  wire logic [7:0]                  rd_data,
    output      optical_module_pkg::bus_req_s req,
    // data pin drive
    output      logic                        sda_oe
);
    import optical_module_pkg::*;

    twowire_state_e state_q;
    twowire_state_e state_d;
    logic [2:0]     cnt_q;
    logic [2:0]     cnt_d;
    logic [7:0]     sh_q;
    logic [7:0]     sh_d;
    logic           rw_q;
    logic           rw_d;
    logic           ackon_q;
    logic           ackon_d;
    logic           wrote_q;
    logic           wrote_d;
    logic           oe_q;
    logic           oe_d;
    bus_req_s       req_q;
    bus_req_s       req_d;
    logic           scl_p_q;
    logic           sda_p_q;
    logic           start;
    logic           stop;
    logic           rise;
    logic           fall;
    logic [7:0]     byte_in;
    logic [7:0]     dev_word;

    assign start    = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop     = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign rise     = scl_s && !scl_p_q;
    assign fall     = !scl_s && scl_p_q;
    assign byte_in  = {sh_q[6:0], sda_s};
    assign dev_word = {byte_in[7:1], 1'b0};

    always_comb
    begin
        state_d        = state_q;
        cnt_d          = cnt_q;
        sh_d           = sh_q;
        rw_d           = rw_q;
        ackon_d        = ackon_q;
        wrote_d        = wrote_q;
        oe_d           = oe_q;
        req_d          = req_q;
        req_d.wr_stb   = 1'b0;
        req_d.stop_wr  = 1'b0;
        if (start)
        begin
            state_d = st_addr;
            cnt_d   = 3'h0;
            oe_d    = 1'b0;
            ackon_d = 1'b0;
        end
        else if (stop)
        begin
            state_d       = st_idle;
            oe_d          = 1'b0;
            req_d.stop_wr = wrote_q;
            wrote_d       = 1'b0;
        end
        else if (rise)
        begin
            unique case (state_q)
                st_addr, st_reg, st_wr:
                begin
                    sh_d  = byte_in;
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h7)
                    begin
                        if (state_q == st_addr)
                        begin
                            // not ready or busy writing: stay silent so the host sees a nack
                            if (accept && (dev_word == `DEV_ID_ADDR || dev_word == `DEV_DIAG_ADDR))
                            begin
                                state_d   = st_aack;
                                req_d.dev = (dev_word == `DEV_DIAG_ADDR);
                                rw_d      = byte_in[0];
                            end
                            else
                                state_d = st_idle;
                        end
                        else if (state_q == st_reg)
                        begin
                            req_d.addr = byte_in;
                            state_d    = st_rack;
                        end
                        else
                        begin
                            req_d.data   = byte_in;
                            req_d.wr_stb = 1'b1;
                            wrote_d      = 1'b1;
                            state_d      = st_wack;
                        end
                    end
                end
                st_rd:
                begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h7)
                    begin
                        state_d    = st_mack;
                        req_d.addr = req_q.addr + 8'h01;
                    end
                end
                st_mack:
                begin
                    if (sda_s)
                        state_d = st_idle;
                    else
                        ackon_d = 1'b1;
                end
                default:
                begin
                end
            endcase
        end
        else if (fall)
        begin
            unique case (state_q)
                st_aack, st_rack, st_wack:
                begin
                    if (!ackon_q)
                    begin
                        oe_d    = 1'b1;
                        ackon_d = 1'b1;
                    end
                    else
                    begin
                        ackon_d = 1'b0;
                        oe_d    = 1'b0;
                        cnt_d   = 3'h0;
                        if (state_q == st_aack && rw_q)
                        begin
                            sh_d    = rd_data;
                            oe_d    = !rd_data[7];
                            state_d = st_rd;
                        end
                        else if (state_q == st_aack)
                            state_d = st_reg;
                        else if (state_q == st_wack)
                        begin
                            state_d    = st_wr;
                            req_d.addr = req_q.addr + 8'h01;
                        end
                        else
                            state_d = st_wr;
                    end
                end
                st_rd:
                begin
                    oe_d = !sh_q[6];
                    sh_d = {sh_q[6:0], 1'b0};
                end
                st_mack:
                begin
                    oe_d = 1'b0;
                    if (ackon_q)
                    begin
                        sh_d    = rd_data;
                        oe_d    = !rd_data[7];
                        ackon_d = 1'b0;
                        cnt_d   = 3'h0;
                        state_d = st_rd;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= st_idle;
            cnt_q   <= 3'h0;
            sh_q    <= 8'h00;
            rw_q    <= 1'b0;
            ackon_q <= 1'b0;
            wrote_q <= 1'b0;
            oe_q    <= 1'b0;
            req_q   <= '0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            rw_q    <= rw_d;
            ackon_q <= ackon_d;
            wrote_q <= wrote_d;
            oe_q    <= oe_d;
            req_q   <= req_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign req    = req_q;
    assign sda_oe = oe_q;

endmodule : twowire_slave

/* core/optical_module_ctrl.sv */
// low-speed control and status logic of a pluggable optical module
`timescale 1ns/1ps
`include "optical_module_regs.svh"
module optical_module_ctrl
#(
    parameter int unsigned SERIAL_CYC = `T_SERIAL_CYC,
    parameter int unsigned DATA_CYC   = `T_DATA_CYC,
    parameter int unsigned WRITE_CYC  = `T_WRITE_CYC
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ce,
    // host control pin and analog monitors
    input  wire logic tx_off_pin,
    input  wire logic laser_fault,
    input  wire logic rx_power_low,
    // laser driver
    output      logic laser_en,
    // open-drain status pins
    output      logic tx_fault_o,
    output      logic tx_fault_oe,
    output      logic rx_signal_lost_o,
    output      logic rx_signal_lost_oe,
    output      logic present_o,
    output      logic present_oe,
    // two-wire serial pins
    input  wire logic scl_pin,
    input  wire logic sda_i,
    output      logic sda_o,
    output      logic sda_oe
);
    import optical_module_pkg::*;

    localparam int SW = $clog2(SERIAL_CYC + 1);
    localparam int DW = $clog2(DATA_CYC + 1);
    localparam int WW = $clog2(WRITE_CYC + 1);
    localparam int RW = $clog2(`T_RESET_CYC + 1);
    localparam logic [RW-1:0] RESET_LIM = RW'(`T_RESET_CYC);
    localparam int OFF_BOUND   = `T_OFF_CYC;
    localparam int FAULT_BOUND = `T_FAULT_CYC;
    localparam int LOSS_BOUND  = `T_LOSS_CYC;

    // pin synchronisers
    logic [4:0] pin_raw;
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic       tx_off_s;
    logic       fault_s;
    logic       rxlow_s;
    logic       scl_s;
    logic       sda_s;

    assign pin_raw  = {sda_i, scl_pin, rx_power_low, laser_fault, tx_off_pin};
    assign tx_off_s = sync_q[0];
    assign fault_s  = sync_q[1];
    assign rxlow_s  = sync_q[2];
    assign scl_s    = sync_q[3];
    assign sda_s    = sync_q[4];

    // open pins and idle bus lines read high, so both stages reset to one
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    meta_q[gi] <= 1'b1;
                    sync_q[gi] <= 1'b1;
                end
                else if (ce)
                begin
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    // power-on and write-cycle timers
    logic [SW-1:0] serial_cnt_q;
    logic [SW-1:0] serial_cnt_d;
    logic [DW-1:0] data_cnt_q;
    logic [DW-1:0] data_cnt_d;
    logic [WW-1:0] busy_cnt_q;
    logic [WW-1:0] busy_cnt_d;
    logic          serial_rdy;
    logic          data_rdy;
    logic          accept;
    bus_req_s      req;

    assign serial_rdy = (serial_cnt_q == SW'(SERIAL_CYC));
    assign data_rdy   = (data_cnt_q == DW'(DATA_CYC));
    assign accept     = serial_rdy && (busy_cnt_q == '0);

    always_comb
    begin
        serial_cnt_d = serial_cnt_q;
        data_cnt_d   = data_cnt_q;
        busy_cnt_d   = busy_cnt_q;
        if (!serial_rdy)
            serial_cnt_d = serial_cnt_q + SW'(1);
        if (!data_rdy)
            data_cnt_d = data_cnt_q + DW'(1);
        if (req.stop_wr)
            busy_cnt_d = WW'(WRITE_CYC);
        else if (busy_cnt_q != '0)
            busy_cnt_d = busy_cnt_q - WW'(1);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_cnt_q <= '0;
            data_cnt_q   <= '0;
            busy_cnt_q   <= '0;
        end
        else if (ce)
        begin
            serial_cnt_q <= serial_cnt_d;
            data_cnt_q   <= data_cnt_d;
            busy_cnt_q   <= busy_cnt_d;
        end
    end

    // transmitter control, fault latch and signal-lost report
    logic          tx_off_p_q;
    logic [RW-1:0] hi_cnt_q;
    logic [RW-1:0] hi_cnt_d;
    logic          fault_q;
    logic          fault_d;
    logic          soft_dis_q;
    logic          soft_dis_d;
    logic          laser_en_q;
    logic          laser_en_d;
    logic          lost_q;
    logic          lost_d;
    logic          reset_ev;
    logic          status_wr;

    assign status_wr = req.wr_stb && req.dev && (req.addr == `STATUS_BYTE);
    // a release after a long enough high time clears the latched shutdown
    assign reset_ev  = tx_off_p_q && !tx_off_s && (hi_cnt_q == RESET_LIM);

    always_comb
    begin
        hi_cnt_d   = '0;
        soft_dis_d = soft_dis_q;
        if (tx_off_s)
            hi_cnt_d = (hi_cnt_q == RESET_LIM) ? hi_cnt_q : hi_cnt_q + RW'(1);
        if (status_wr)
            soft_dis_d = req.data[`ST_SOFTDIS_BIT];
        // the detector only means something while lasing; a new fault beats the clear
        fault_d    = (fault_s && laser_en_q) || (fault_q && !reset_ev);
        laser_en_d = !tx_off_s && !soft_dis_q && !fault_q;
        lost_d     = rxlow_s;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_off_p_q <= 1'b1;
            hi_cnt_q   <= '0;
            fault_q    <= 1'b0;
            soft_dis_q <= 1'b0;
            laser_en_q <= 1'b0;
            lost_q     <= 1'b1;
        end
        else if (ce)
        begin
            tx_off_p_q <= tx_off_s;
            hi_cnt_q   <= hi_cnt_d;
            fault_q    <= fault_d;
            soft_dis_q <= soft_dis_d;
            laser_en_q <= laser_en_d;
            lost_q     <= lost_d;
        end
    end

    // identification and diagnostic memory, page select in the top address bit
    logic [7:0] mem_q [0:`MEM_DEPTH-1];
    logic [7:0] status_byte;
    logic [7:0] rd_data;

    always_comb
    begin
        status_byte                  = 8'h00;
        status_byte[`ST_TXOFF_BIT]   = tx_off_s;
        status_byte[`ST_SOFTDIS_BIT] = soft_dis_q;
        status_byte[`ST_FAULT_BIT]   = fault_q;
        status_byte[`ST_LOST_BIT]    = lost_q;
        status_byte[`ST_READY_BIT]   = data_rdy;
        if (req.dev && req.addr == `STATUS_BYTE)
            rd_data = status_byte;
        else
            rd_data = mem_q[{req.dev, req.addr}];
    end

    // array reset keeps reads defined; the status byte lives in flops, not here
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < `MEM_DEPTH; i++)
                mem_q[i] <= 8'h00;
        end
        else if (ce && req.wr_stb && !status_wr)
            mem_q[{req.dev, req.addr}] <= req.data;
    end

    twowire_slave u_slave
    (
        .clk     (clk),
        .rstn    (rstn),
        .ce      (ce),
        .scl_s   (scl_s),
        .sda_s   (sda_s),
        .accept  (accept),
        .rd_data (rd_data),
        .req     (req),
        .sda_oe  (sda_oe)
    );

    // open-drain pins pull low when enabled; the host pull-up makes the high level
    assign laser_en          = laser_en_q;
    assign tx_fault_o        = 1'b0;
    assign tx_fault_oe       = !fault_q;
    assign rx_signal_lost_o  = 1'b0;
    assign rx_signal_lost_oe = !lost_q;
    assign present_o         = 1'b0;
    assign present_oe        = 1'b1;
    assign sda_o             = 1'b0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_fault_cause;
        $rose(fault_q) |-> $past(fault_s) && $past(laser_en_q);
    endproperty
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault latched without a detected fault while lasing");

    property p_tx_off;
        (tx_off_s || soft_dis_q) |=> !laser_en;
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("laser on while disabled");

    property p_off_time;
        $rose(tx_off_pin) |-> ##[1:OFF_BOUND] !laser_en;
    endproperty
    a_off_time: assert property (p_off_time)
        else $error("laser not off in time after off input rose");

    property p_on_time;
        $fell(tx_off_pin) && !soft_dis_q && !fault_q && !laser_fault
            |-> ##[1:8] (laser_en || fault_q || tx_off_pin);
    endproperty
    a_on_time: assert property (p_on_time)
        else $error("laser not on after off input fell");

    property p_fault_time;
        $rose(laser_fault) && laser_en && !tx_off_pin && !soft_dis_q
            |-> ##[1:FAULT_BOUND] !tx_fault_oe;
    endproperty
    a_fault_time: assert property (p_fault_time)
        else $error("fault output late");

    property p_loss_time;
        $changed(rx_power_low) |-> ##[1:LOSS_BOUND] (lost_q == rx_power_low);
    endproperty
    a_loss_time: assert property (p_loss_time)
        else $error("signal-lost output late");

    property p_short_pulse;
        fault_q && $fell(tx_off_s) && (hi_cnt_q < RESET_LIM) |=> fault_q;
    endproperty
    a_short_pulse: assert property (p_short_pulse)
        else $error("short off pulse cleared the fault");

    property p_soft_write;
        status_wr |=> (soft_dis_q == $past(req.data[`ST_SOFTDIS_BIT])) ##[1:4] !laser_en || !soft_dis_q;
    endproperty
    a_soft_write: assert property (p_soft_write)
        else $error("soft disable write not applied");

    property p_not_ready;
        !serial_rdy |-> !sda_oe;
    endproperty
    a_not_ready: assert property (p_not_ready)
        else $error("bus answered before ready");

    property p_write_busy;
        req.stop_wr |=> (busy_cnt_q != '0) && !sda_oe;
    endproperty
    a_write_busy: assert property (p_write_busy)
        else $error("write cycle not started at stop");

    c_fault_clear: cover property ($fell(fault_q));
    c_soft_off: cover property (status_wr && req.data[`ST_SOFTDIS_BIT]);
    c_status_read: cover property (req.dev && req.addr == `STATUS_BYTE && sda_oe);
    c_loss: cover property ($rose(lost_q));

endmodule : optical_module_ctrl

/* test/twowire_host.sv */
// two-wire host master model for the module's serial pins
`timescale 1ns/1ps
module twowire_host
(
    // clock and resolved data wire
    input  wire logic clk,
    input  wire logic sda,
    // driven lines, sda_low pulls the data wire
    output      logic scl,
    output      logic sda_low
);
    event       got;
    logic [7:0] got_b;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // four clocks a half period, three of them to a 1200 ns serial bit
    task automatic hp;
        repeat (4) @(posedge clk);
    endtask : hp
    task automatic start;
        sda_low <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_low <= 1'b1;
        hp();
        scl <= 1'b0;
        hp();
    endtask : start
    task automatic stop;
        sda_low <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_low <= 1'b0;
        hp();
    endtask : stop
    // data moves half a period away from both clock edges
    task automatic xbit(input logic b, output logic r);
        sda_low <= ~b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda;
        scl <= 1'b0;
        hp();
    endtask : xbit
    task automatic wbyte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(b[i], r);
        xbit(1'b1, r);
        got_b = {7'h00, ~r};
        -> got;
    endtask : wbyte
    // always the last byte: the host answers with no ack
    task automatic rbyte;
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(1'b1, got_b[i]);
        xbit(1'b1, r);
        -> got;
    endtask : rbyte
endmodule : twowire_host

/* test/tb.sv */
// self-checking bench for the optical module control block
`timescale 1ns/1ps
module tb;
    logic       clk, rstn, tx_off_pin, laser_fault, rx_power_low;
    logic       laser_en, tx_fault_oe, rx_signal_lost_oe, present_oe;
    logic       sda_oe, scl, host_low, sda;
    logic [7:0] a, d;
    logic [7:0] q[$];
    int         errors, check_count, tn;
    event       pin_ev;
    assign sda = (host_low | sda_oe) ? 1'b0 : 1'b1;
    always #50 clk = ~clk;
    // write cycle outlasts one start and address byte, so a busy-time access is refused
    optical_module_ctrl #(.SERIAL_CYC(200), .DATA_CYC(300), .WRITE_CYC(200)) optical_module_ctrl_i
    (
        .clk(clk), .rstn(rstn), .ce(1'b1), .tx_off_pin(tx_off_pin),
        .laser_fault(laser_fault), .rx_power_low(rx_power_low), .laser_en(laser_en),
        .tx_fault_o(), .tx_fault_oe(tx_fault_oe), .rx_signal_lost_o(),
        .rx_signal_lost_oe(rx_signal_lost_oe), .present_o(), .present_oe(present_oe),
        .scl_pin(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe)
    );
    twowire_host twowire_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    always @(pin_ev) check({4'h0, present_oe, laser_en, tx_fault_oe, rx_signal_lost_oe},
                           q.pop_front());
    always @(twowire_host_i.got) check(twowire_host_i.got_b, q.pop_front());
    // pins are sampled mid-cycle, away from the edge that updates them
    task automatic pins(input logic [7:0] e);
        @(negedge clk);
        q.push_back(e);
        -> pin_ev;
        @(posedge clk);
    endtask : pins
    task automatic wr(input logic [7:0] b, input logic e);
        q.push_back({7'h00, e});
        twowire_host_i.wbyte(b);
    endtask : wr
    task automatic wt(input logic [7:0] dev, input logic [7:0] p, input logic [7:0] v);
        twowire_host_i.start();
        wr(dev, 1'b1);
        wr(p, 1'b1);
        wr(v, 1'b1);
        twowire_host_i.stop();
    endtask : wt
    task automatic rd(input logic [7:0] dev, input logic [7:0] p, input logic [7:0] e);
        twowire_host_i.start();
        wr(dev, 1'b1);
        wr(p, 1'b1);
        twowire_host_i.start();
        wr(dev | 8'h01, 1'b1);
        q.push_back(e);
        twowire_host_i.rbyte();
        twowire_host_i.stop();
    endtask : rd
    task automatic tend;
        tn++;
        $display("test %0d finished", tn);
    endtask : tend
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (30000) @(posedge clk);
        errors++;
        finish_test();
    end
    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        tx_off_pin = 1'b1;
        laser_fault = 1'b0;
        rx_power_low = 1'b1;
        void'($urandom(86));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        pins(8'h0a);
        twowire_host_i.start();
        wr(8'ha2, 1'b0);
        twowire_host_i.stop();
        tend();
        repeat (300) @(posedge clk);
        tx_off_pin <= 1'b0;
        rx_power_low <= 1'b0;
        repeat (5) @(posedge clk);
        pins(8'h0f);
        tx_off_pin <= 1'b1;
        repeat (4) @(posedge clk);
        pins(8'h0b);
        tx_off_pin <= 1'b0;
        repeat (5) @(posedge clk);
        pins(8'h0f);
        laser_fault <= 1'b1;
        repeat (5) @(posedge clk);
        pins(8'h09);
        laser_fault <= 1'b0;
        repeat (20) @(posedge clk);
        pins(8'h09);
        rd(8'ha2, 8'h6e, 8'h05);
        tx_off_pin <= 1'b1;
        repeat (50) @(posedge clk);
        tx_off_pin <= 1'b0;
        repeat (5) @(posedge clk);
        pins(8'h09);
        tx_off_pin <= 1'b1;
        repeat (110) @(posedge clk);
        tx_off_pin <= 1'b0;
        repeat (5) @(posedge clk);
        pins(8'h0f);
        tend();
        wt(8'ha2, 8'h6e, 8'hff);
        repeat (250) @(posedge clk);
        pins(8'h0b);
        rd(8'ha2, 8'h6e, 8'h41);
        wt(8'ha2, 8'h6e, 8'h00);
        repeat (250) @(posedge clk);
        pins(8'h0f);
        tx_off_pin <= 1'b1;
        rx_power_low <= 1'b1;
        repeat (5) @(posedge clk);
        rd(8'ha2, 8'h6e, 8'h83);
        tend();
        a = 8'($urandom());
        d = 8'($urandom());
        wt(8'ha0, a, d);
        twowire_host_i.start();
        wr(8'ha0, 1'b0);
        twowire_host_i.stop();
        repeat (250) @(posedge clk);
        rd(8'ha0, a, d);
        tend();
        finish_test();
    end
endmodule : tb
